// ### hdl/alarm_out_pkg.sv
package alarm_out_pkg;

	localparam int CH_N = 3;
	localparam int VAL_W = 16;
	localparam int PAT_N = 8;
	localparam int STEP_N = 16;

	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] ADDR_PV = 32'h0000_0008;
	localparam logic [31:0] ADDR_SP = 32'h0000_000C;
	localparam logic [31:0] ADDR_SHIFT = 32'h0000_0010;
	localparam logic [31:0] ADDR_PATSEL = 32'h0000_0014;
	localparam logic [31:0] ADDR_STEPCNT = 32'h0000_0018;
	localparam logic [31:0] ADDR_STEPSEL = 32'h0000_001C;
	localparam logic [31:0] ADDR_STEPTIME = 32'h0000_0020;
	localparam logic [31:0] ADDR_CHCFG0 = 32'h0000_0040;
	localparam logic [31:0] ADDR_HYST0 = 32'h0000_0050;
	localparam logic [31:0] ADDR_ALVAL0 = 32'h0000_0060;
	localparam logic [31:0] CH_STRIDE = 32'h0000_0004;

	// Control register bits; event bits are write-one pulses.
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PAT_START = 1;
	localparam int CTRL_NEXT_STEP = 2;
	localparam int CTRL_ADVANCE = 3;

	// Channel config layout: type [3:0], open-in-alarm [4], assigned [5].
	localparam int CFG_TYPE_LSB = 0;
	localparam int CFG_OPEN = 4;
	localparam int CFG_ASSIGN = 5;

	localparam logic [3:0] TYPE_RESET = 4'h2;
	localparam logic [3:0] TYPE_MAX = 4'hB;
	localparam logic [VAL_W-1:0] HYST_RESET = 16'h0002;
	localparam logic [2:0] PAT_RESET = 3'h0;
	localparam logic [4:0] STEPCNT_RESET = 5'h08;
	localparam logic [4:0] STEPCNT_MIN = 5'h01;
	localparam logic [4:0] STEPCNT_MAX = 5'h10;
	localparam logic [15:0] STEPTIME_MAX = 16'h9959;
	localparam logic [3:0] BCD_MIN_MAX = 4'h5;

	typedef enum logic [3:0] {
		AT_NONE = 4'h0,
		AT_DEV_UL = 4'h1,
		AT_DEV_UP = 4'h2,
		AT_DEV_LO = 4'h3,
		AT_DEV_RNG = 4'h4,
		AT_DEV_UL_SB = 4'h5,
		AT_DEV_UP_SB = 4'h6,
		AT_DEV_LO_SB = 4'h7,
		AT_ABS_UP = 4'h8,
		AT_ABS_LO = 4'h9,
		AT_ABS_UP_SB = 4'hA,
		AT_ABS_LO_SB = 4'hB
	} alarm_type_t;

endpackage

// ### hdl/process_alarm_output_logic.sv
module process_alarm_output_logic
	import alarm_out_pkg::*;
(
	input  wire logic                         CLK,
	input  wire logic                         SRST,
	input  wire logic                         PSEL,
	input  wire logic                         PENABLE,
	input  wire logic                         PWRITE,
	input  wire logic [31:0]                  PADDR,
	input  wire logic [31:0]                  PWDATA,
	output logic      [31:0]                  PRDATA,
	output logic                              PREADY,
	output logic                              PSLVERR,
	input  wire logic                         SAMPLE_STROBE,
	output logic      [alarm_out_pkg::CH_N-1:0] ALARM_OUT,
	output logic      [alarm_out_pkg::CH_N-1:0] ALARM_LED
);
	import alarm_out_pkg::*;

	// --------------------------------------------------------------------
	// Register storage
	// --------------------------------------------------------------------
	logic                   run_q;
	logic signed [VAL_W-1:0] pv_q, sp_q, shift_q;
	logic [2:0]             pattern_selector_q;
	logic [3:0]             step_sel_q;
	logic [4:0]             step_count_q [PAT_N];
	logic [15:0]            step_time_q [PAT_N][STEP_N];
	logic [3:0]             type_q [CH_N];
	logic [CH_N-1:0]        open_q, assign_q;
	logic [VAL_W-1:0]       hyst_q [CH_N];
	logic signed [VAL_W-1:0] alval_q [CH_N];
	logic [CH_N-1:0]        alarm_q, standby_q;
	logic                   rearm_q;
	logic                   access_done_q;

	// --------------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------------
	// The access is judged in its first cycle, so that PSLVERR stands beside PREADY,
	// but a write only lands at the edge at which the master sees PREADY high.
	wire        acc_first = PSEL && PENABLE && !access_done_q;
	wire        wr_en = PSEL && PENABLE && PWRITE && access_done_q;
	wire        rd_en = acc_first && !PWRITE;
	wire [31:0] ch_off = PADDR - ADDR_CHCFG0;
	wire [31:0] hy_off = PADDR - ADDR_HYST0;
	wire [31:0] al_off = PADDR - ADDR_ALVAL0;
	wire        is_cfg = PADDR >= ADDR_CHCFG0 && ch_off < CH_N * CH_STRIDE && PADDR[1:0] == 2'b00;
	wire        is_hy = PADDR >= ADDR_HYST0 && hy_off < CH_N * CH_STRIDE && PADDR[1:0] == 2'b00;
	wire        is_al = PADDR >= ADDR_ALVAL0 && al_off < CH_N * CH_STRIDE && PADDR[1:0] == 2'b00;
	wire [1:0]  cfg_ch = ch_off[3:2];
	wire [1:0]  hy_ch = hy_off[3:2];
	wire [1:0]  al_ch = al_off[3:2];
	wire        is_fixed = PADDR == ADDR_CTRL || PADDR == ADDR_STATUS || PADDR == ADDR_PV
		|| PADDR == ADDR_SP || PADDR == ADDR_SHIFT || PADDR == ADDR_PATSEL
		|| PADDR == ADDR_STEPCNT || PADDR == ADDR_STEPSEL || PADDR == ADDR_STEPTIME;
	wire        mapped = is_fixed || is_cfg || is_hy || is_al;

	// Out-of-range parameter values are refused with PSLVERR and leave state unchanged.
	wire        pat_bad = PADDR == ADDR_PATSEL && (run_q || PWDATA[31:3] != '0);
	wire        cnt_bad = PADDR == ADDR_STEPCNT
		&& (PWDATA[4:0] < STEPCNT_MIN || PWDATA[4:0] > STEPCNT_MAX || PWDATA[31:5] != '0);
	wire        time_bad = PADDR == ADDR_STEPTIME
		&& (PWDATA[15:0] > STEPTIME_MAX || PWDATA[7:4] > BCD_MIN_MAX || PWDATA[31:16] != '0);
	wire        type_bad = is_cfg && PWDATA[3:0] > TYPE_MAX;
	wire        al_bad = is_al && !assign_q[al_ch];
	wire        wr_bad = !mapped || pat_bad || cnt_bad || time_bad || type_bad || al_bad;
	wire        wr_ok = wr_en && !wr_bad;
	wire        err_d = (acc_first && PWRITE && wr_bad) || (rd_en && !mapped);

	wire [31:0] ctrl_evt = (wr_ok && PADDR == ADDR_CTRL) ? PWDATA : 32'h0000_0000;
	// Run start, pattern start, step change and advance all re-arm standby.
	wire        rearm_evt = (ctrl_evt[CTRL_RUN] && !run_q) || ctrl_evt[CTRL_PAT_START]
		|| ctrl_evt[CTRL_NEXT_STEP] || ctrl_evt[CTRL_ADVANCE];
	wire        chg_evt = wr_ok && ((PADDR == ADDR_SP && PWDATA[VAL_W-1:0] != sp_q)
		|| (PADDR == ADDR_SHIFT && PWDATA[VAL_W-1:0] != shift_q)
		|| (is_al && PWDATA[VAL_W-1:0] != alval_q[al_ch]));

	// --------------------------------------------------------------------
	// Alarm evaluation
	// --------------------------------------------------------------------
	function automatic logic type_is_dev(input logic [3:0] t);
		return t >= AT_DEV_UL && t <= AT_DEV_LO_SB;
	endfunction

	function automatic logic type_is_sb(input logic [3:0] t);
		return (t >= AT_DEV_UL_SB && t <= AT_DEV_LO_SB) || t == AT_ABS_UP_SB || t == AT_ABS_LO_SB;
	endfunction

	// Evaluation in 18 bits keeps set point plus offset plus hysteresis free of wrap.
	function automatic logic eval_alarm(input logic [3:0] t, input logic signed [17:0] pvs,
		input logic signed [17:0] sp, input logic signed [17:0] x,
		input logic signed [17:0] h, input logic was_on);
		logic signed [17:0] ax, up, lo, hh;
		logic               r;
		ax = (x < 0) ? -x : x;
		up = type_is_dev(t) ? sp + x : x;
		lo = type_is_dev(t) ? sp - x : x;
		hh = was_on ? h : 18'sd0;
		r = 1'b0;
		unique case (t)
			AT_DEV_UL, AT_DEV_UL_SB: begin
				if (x < 0 && t == AT_DEV_UL)
					r = 1'b1;
				else if (x >= 0)
					r = (pvs > sp + ax - hh) || (pvs < sp - ax + hh);
			end
			AT_DEV_RNG: r = x >= 0 && pvs <= sp + ax + hh && pvs >= sp - ax - hh;
			AT_DEV_UP, AT_DEV_UP_SB, AT_ABS_UP, AT_ABS_UP_SB: r = pvs > up - hh;
			AT_DEV_LO, AT_DEV_LO_SB: r = pvs < lo + hh;
			AT_ABS_LO, AT_ABS_LO_SB: r = pvs < x + hh;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	logic [CH_N-1:0] in_range, alarm_d, standby_d;
	wire signed [17:0] pv_shifted = 18'(pv_q) + 18'(shift_q);

	always_comb begin
		for (int c = 0; c < CH_N; c++) begin
			in_range[c] = assign_q[c] && eval_alarm(type_q[c], pv_shifted, 18'(sp_q),
				18'(alval_q[c]), 18'($signed({1'b0, hyst_q[c]})), alarm_q[c]);
			standby_d[c] = standby_q[c];
			alarm_d[c] = alarm_q[c];
			if (SAMPLE_STROBE) begin
				if (standby_q[c] && type_is_sb(type_q[c])) begin
					alarm_d[c] = 1'b0;
					if (!in_range[c])
						standby_d[c] = 1'b0;
				end else begin
					alarm_d[c] = in_range[c];
					if (in_range[c])
						standby_d[c] = 1'b0;
				end
			end
			if (rearm_q)
				standby_d[c] = 1'b1;
		end
	end

	// --------------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------------
	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (PADDR == ADDR_CTRL)
			rdata_d[CTRL_RUN] = run_q;
		else if (PADDR == ADDR_STATUS)
			rdata_d = {26'h0, standby_q, alarm_q};
		else if (PADDR == ADDR_PV)
			rdata_d = 32'($signed(pv_q));
		else if (PADDR == ADDR_SP)
			rdata_d = 32'($signed(sp_q));
		else if (PADDR == ADDR_SHIFT)
			rdata_d = 32'($signed(shift_q));
		else if (PADDR == ADDR_PATSEL)
			rdata_d = {29'h0, pattern_selector_q};
		else if (PADDR == ADDR_STEPCNT)
			rdata_d = {27'h0, step_count_q[pattern_selector_q]};
		else if (PADDR == ADDR_STEPSEL)
			rdata_d = {28'h0, step_sel_q};
		else if (PADDR == ADDR_STEPTIME)
			rdata_d = {16'h0, step_time_q[pattern_selector_q][step_sel_q]};
		else if (is_cfg)
			rdata_d = {26'h0, assign_q[cfg_ch], open_q[cfg_ch], type_q[cfg_ch]};
		else if (is_hy)
			rdata_d = {16'h0, hyst_q[hy_ch]};
		else if (is_al)
			rdata_d = 32'($signed(alval_q[al_ch]));
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			run_q <= 1'b0;
			pv_q <= '0;
			sp_q <= '0;
			shift_q <= '0;
			pattern_selector_q <= PAT_RESET;
			step_sel_q <= '0;
			for (int p = 0; p < PAT_N; p++) begin
				step_count_q[p] <= STEPCNT_RESET;
				for (int s = 0; s < STEP_N; s++)
					step_time_q[p][s] <= '0;
			end
			for (int c = 0; c < CH_N; c++) begin
				type_q[c] <= TYPE_RESET;
				hyst_q[c] <= HYST_RESET;
				alval_q[c] <= '0;
			end
			open_q <= '0;
			assign_q <= '0;
			alarm_q <= '0;
			standby_q <= '1;
			rearm_q <= 1'b0;
			access_done_q <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			ALARM_OUT <= '0;
			ALARM_LED <= '0;
		end else begin
			access_done_q <= PSEL && PENABLE && !access_done_q;
			PREADY <= PSEL && PENABLE && !access_done_q;
			PSLVERR <= err_d;
			if (rd_en)
				PRDATA <= mapped ? rdata_d : 32'h0000_0000;
			rearm_q <= rearm_evt || chg_evt;
			alarm_q <= alarm_d;
			standby_q <= standby_d;
			for (int c = 0; c < CH_N; c++) begin
				ALARM_OUT[c] <= alarm_d[c] ^ open_q[c];
				ALARM_LED[c] <= alarm_d[c];
			end
			if (wr_ok) begin
				if (PADDR == ADDR_CTRL)
					run_q <= PWDATA[CTRL_RUN];
				if (PADDR == ADDR_PV)
					pv_q <= PWDATA[VAL_W-1:0];
				if (PADDR == ADDR_SP)
					sp_q <= PWDATA[VAL_W-1:0];
				if (PADDR == ADDR_SHIFT)
					shift_q <= PWDATA[VAL_W-1:0];
				if (PADDR == ADDR_PATSEL)
					pattern_selector_q <= PWDATA[2:0];
				if (PADDR == ADDR_STEPCNT)
					step_count_q[pattern_selector_q] <= PWDATA[4:0];
				if (PADDR == ADDR_STEPSEL)
					step_sel_q <= PWDATA[3:0];
				if (PADDR == ADDR_STEPTIME)
					step_time_q[pattern_selector_q][step_sel_q] <= PWDATA[15:0];
				if (is_cfg) begin
					type_q[cfg_ch] <= PWDATA[CFG_TYPE_LSB +: 4];
					open_q[cfg_ch] <= PWDATA[CFG_OPEN];
					assign_q[cfg_ch] <= PWDATA[CFG_ASSIGN];
				end
				if (is_hy)
					hyst_q[hy_ch] <= PWDATA[VAL_W-1:0];
				if (is_al)
					alval_q[al_ch] <= PWDATA[VAL_W-1:0];
			end
		end
	end

endmodule // process_alarm_output_logic

// ### verification/alarm_contact_load.sv
module alarm_contact_load (
	input wire logic       clk,
	input wire logic [2:0] contact,
	output logic     [2:0] energised
);
	timeunit 1ns;
	timeprecision 1ns;
	// The load lags the contact by one clock, as a relay coil would.
	always_ff @(posedge clk) begin
		energised <= contact;
	end
endmodule // alarm_contact_load

// ### verification/alarm_props.sv
module alarm_props
	import alarm_out_pkg::*;
(
	input wire logic                           CLK,
	input wire logic                           SRST,
	input wire logic                           PSEL,
	input wire logic                           PENABLE,
	input wire logic                           PWRITE,
	input wire logic [31:0]                    PADDR,
	input wire logic [31:0]                    PWDATA,
	input wire logic [31:0]                    PRDATA,
	input wire logic                           PREADY,
	input wire logic                           PSLVERR,
	input wire logic                           SAMPLE_STROBE,
	input wire logic [alarm_out_pkg::CH_N-1:0] ALARM_OUT,
	input wire logic [alarm_out_pkg::CH_N-1:0] ALARM_LED
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic       wr_end = PREADY && PWRITE;
	wire logic [4:0] word   = PADDR[6:2];
	wire logic       hole   = (PADDR[31:7] != 25'h0) || (word > 5'h08 && word < 5'h10)
		|| word == 5'h13 || word == 5'h17 || word > 5'h1A;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SRST);
	property p_answer; PSEL && PENABLE && !$past(PENABLE) |=> PREADY ##1 !PREADY; endproperty
	a_answer: assert property (p_answer) else $error("access not answered in two cycles");
	property p_hole; PREADY && hole |-> PSLVERR && (PWRITE || PRDATA == 32'h0); endproperty
	a_hole: assert property (p_hole) else $error("unmapped access not refused");
	property p_pat; wr_end && PADDR == ADDR_PATSEL && PWDATA > 32'h7 |-> PSLVERR; endproperty
	a_pat: assert property (p_pat) else $error("pattern above range accepted");
	property p_cnt; wr_end && PADDR == ADDR_STEPCNT && (PWDATA < 32'h1 || PWDATA > 32'h10)
		|-> PSLVERR; endproperty
	a_cnt: assert property (p_cnt) else $error("step count out of range accepted");
	property p_time; wr_end && PADDR == ADDR_STEPTIME && (PWDATA[15:0] > STEPTIME_MAX
		|| PWDATA[7:4] > BCD_MIN_MAX) |-> PSLVERR; endproperty
	a_time: assert property (p_time) else $error("bad step time accepted");
	property p_type; wr_end && PADDR[31:4] == 28'h4 && PWDATA[3:0] > TYPE_MAX |-> PSLVERR; endproperty
	a_type: assert property (p_type) else $error("unknown alarm type accepted");
	property p_led; $changed(ALARM_LED) |-> $past(SAMPLE_STROBE); endproperty
	a_led: assert property (p_led) else $error("alarm moved without a sample");
	property p_pol; $changed(ALARM_OUT ^ ALARM_LED) |-> $past(PREADY) || $past(PREADY, 2); endproperty
	a_pol: assert property (p_pol) else $error("polarity moved without a write");
	property p_rst; $past(SRST) |-> ALARM_OUT == '0 && ALARM_LED == '0 && !PREADY; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // alarm_props

bind process_alarm_output_logic alarm_props u_props (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_STROBE(SAMPLE_STROBE),
	.ALARM_OUT(ALARM_OUT), .ALARM_LED(ALARM_LED));

// ### verification/process_alarm_output_logic_tb.sv
module process_alarm_output_logic_tb;
	import alarm_out_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'h0, srst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, stb = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, seed = 32'h32B6;
	logic        pready, pslverr;
	logic [2:0]  aout, aled, load;
	int          fail_count = 0, checks_done = 0, sp = 500, sh = 0, thr, inr;
	int          typ[3] = '{AT_ABS_UP, AT_DEV_UP, AT_ABS_UP_SB}, xv[3] = '{1000, 100, 1000};
	int          hy[3] = '{2, 6, 2}, on[3] = '{0, 0, 0}, sb[3] = '{1, 1, 1};
	int          seq[7] = '{1101, 651, 551, 1101, 999, 597, 301};
	logic [31:0] ra[8] = '{ADDR_PATSEL, ADDR_STEPCNT, ADDR_STEPTIME, ADDR_HYST0,
		ADDR_HYST0 + 4, ADDR_HYST0 + 8, ADDR_CHCFG0, ADDR_CHCFG0 + 8};
	int          re[8] = '{0, 8, 0, 2, 2, 2, 2, 2};
	logic [31:0] wa[16] = '{ADDR_PATSEL, ADDR_STEPCNT, ADDR_STEPCNT, ADDR_STEPTIME,
		ADDR_STEPTIME, ADDR_STEPTIME, ADDR_ALVAL0, 32'h30, ADDR_HYST0 + 4, ADDR_CHCFG0,
		ADDR_CHCFG0 + 4, ADDR_CHCFG0 + 8, ADDR_ALVAL0, ADDR_ALVAL0 + 4, ADDR_ALVAL0 + 8, ADDR_SP};
	int          wd[16] = '{8, 0, 17, 'h9960, 'h960, 'h9959, 5, 0, 6, 'h28, 'h32, 'h2A,
		1000, 100, 1000, 500};
	logic        we[16] = '{1, 1, 1, 1, 1, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0};
	logic [31:0] ka[7] = '{ADDR_CTRL, ADDR_CTRL, ADDR_CTRL, ADDR_SP, ADDR_SHIFT,
		ADDR_ALVAL0 + 8, ADDR_CTRL};

	process_alarm_output_logic dut_u (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SAMPLE_STROBE(stb), .ALARM_OUT(aout), .ALARM_LED(aled));
	alarm_contact_load load_u (.clk(clk), .contact(aout), .energised(load));

	always #50 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic e);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		chk({31'h0, pslverr}, {31'h0, e});
		psel <= 1'h0;
		pen <= 1'h0;
	endtask

	// ------------------------------------------------------------
	// Reference alarm model, run once per sample
	// ------------------------------------------------------------
	// Odd process values never land on the even thresholds, so the
	// comparison edges that the design leaves open are never probed.
	task automatic sample(input int pv);
		apb(1'h1, ADDR_PV, pv, 1'h0);
		@(posedge clk);
		stb <= 1'h1;
		@(posedge clk);
		stb <= 1'h0;
		repeat (2) @(posedge clk);
		for (int c = 0; c < 3; c++) begin
			thr = (typ[c] == AT_DEV_UP) ? sp + xv[c] : xv[c];
			inr = on[c] ? (pv + sh > thr - hy[c]) : (pv + sh > thr);
			on[c] = (typ[c] == AT_ABS_UP_SB && sb[c]) ? 0 : inr;
			if (!inr)
				sb[c] = 0;
			chk({31'h0, aled[c]}, on[c]);
			chk({31'h0, load[c]}, on[c] ^ (c == 1));
		end
		apb(1'h0, ADDR_STATUS, 32'h0, 1'h0);
		chk(rd[2:0], on[2] * 4 + on[1] * 2 + on[0]);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		foreach (ra[i]) begin
			apb(1'h0, ra[i], 32'h0, 1'h0);
			chk(rd & 32'h1F, re[i]);
		end
		for (int t = 0; t < 16; t++)
			apb(1'h1, ADDR_CHCFG0, t, t > 11);
		apb(1'h1, ADDR_STEPCNT, 32'h10, 1'h0);
		apb(1'h1, ADDR_CTRL, 32'h1, 1'h0);
		apb(1'h1, ADDR_PATSEL, 32'h3, 1'h1);
		apb(1'h1, ADDR_CTRL, 32'h0, 1'h0);
		apb(1'h1, ADDR_PATSEL, 32'h3, 1'h0);
		apb(1'h0, ADDR_STEPCNT, 32'h0, 1'h0);
		chk(rd, 32'h8);
		apb(1'h1, ADDR_PATSEL, 32'h0, 1'h0);
		apb(1'h0, ADDR_STEPCNT, 32'h0, 1'h0);
		chk(rd, 32'h10);
		apb(1'h0, 32'h80, 32'h0, 1'h1);
		foreach (wa[i])
			apb(1'h1, wa[i], wd[i], we[i]);
		foreach (seq[i])
			sample(seq[i]);
		for (int k = 0; k < 7; k++) begin
			sample(301);
			sample(1101);
			sp += (k == 3) ? 2 : 0;
			sh += (k == 4) ? 2 : 0;
			xv[2] += (k == 5) ? 2 : 0;
			apb(1'h1, ka[k], (k < 3) ? 2 << k : (k == 3) ? sp : (k == 4) ? sh
				: (k == 5) ? xv[2] : 1, 1'h0);
			if (k == 6)
				apb(1'h1, ADDR_CTRL, 32'h0, 1'h0);
			sb = '{1, 1, 1};
			sample(1101);
		end
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			sample(int'(seed % 1000) * 2 + 1);
		end
		give_verdict();
	end

	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
endmodule // process_alarm_output_logic_tb
